/* rtl/ceq_buffer_queues.sv */
// buffer-id queues between host software and the ethernet packet engine
// assumes an axi4-lite master on CLK and an ethernet engine on the same clock
// Operation
// - a write to the transmit push register queues one id taken from data bits 12:0 unless the queue already holds 32.
// - every id stands for sdram address bits 23:11 of a 24-bit buffer address.
// - the transmit queue level reads as a 6-bit count from 0 to 32, zero after reset.
// - an interrupt is raised while the transmit level is at or below its 6-bit low mark.
// - a write to the free pool push register adds one free id taken from data bits 12:0 unless the pool already holds 128.
// - the free pool level reads as an 8-bit count from 0 to 128 of buffers left for the receiver.
// - an interrupt is raised while the free pool level is at or below its 8-bit low mark.
// - while the pool is at or below its low mark only oam packets are queued and others are discarded.
// - a read of the receive pop register removes the oldest id and returns it in bits 12:0.
// - the receive queue level reads as an 8-bit count from 0 to 128, zero after reset.
// - an interrupt is raised while the receive level is at or above its 8-bit high mark.
`timescale 1ns/1ns
module ceq_buffer_queues
    import ceq_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // axi4-lite write channels
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read channels
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // transmit queue toward the ethernet engine
    output logic TXQ_VALID,
    output logic [ADDR_W-1:0] TXQ_ADDR,
    input wire logic TXQ_READY,
    // free buffers handed to the receive side
    output logic POOL_VALID,
    output logic [ADDR_W-1:0] POOL_ADDR,
    input wire logic POOL_TAKE,
    // received buffers offered for the host queue
    input wire logic RXQ_VALID,
    input wire logic [ADDR_W-1:0] RXQ_ADDR,
    input wire logic RXQ_OAM,
    output logic RXQ_READY,
    output logic RXQ_DROP,
    // interrupt
    output logic IRQ
);
    ceq_state_s s;
    ceq_state_s next_s;
    logic [ID_W-1:0] tx_mem [TX_DEPTH];
    logic [ID_W-1:0] pl_mem [RX_DEPTH];
    logic [ID_W-1:0] rx_mem [RX_DEPTH];

    logic wr_fire;
    logic rd_fire;
    logic tx_push;
    logic tx_pop;
    logic pl_push;
    logic pl_pop;
    logic rx_push;
    logic rx_pop;
    logic rx_discard;
    logic tx_full;
    logic pl_full;
    logic rx_full;
    logic tx_low;
    logic pl_low;
    logic rx_high;
    logic [IRQ_W-1:0] irq_event;
    logic [ID_W-1:0] wr_id;
    logic [TX_PW-1:0] tx_wp;
    logic [TX_PW-1:0] tx_rp;

    // transmit ring uses the low pointer bits only
    assign tx_wp = s.tx.wp[TX_PW-1:0];
    assign tx_rp = s.tx.rp[TX_PW-1:0];
    assign wr_id = s.w_data[ID_W-1:0];

    assign tx_full = (s.tx.cnt == RX_CW'(TX_DEPTH));
    assign pl_full = (s.pl.cnt == RX_CW'(RX_DEPTH));
    assign rx_full = (s.rx.cnt == RX_CW'(RX_DEPTH));

    // threshold comparisons
    assign tx_low = (s.tx.cnt[TX_CW-1:0] <= s.tx_mark);
    assign pl_low = (s.pl.cnt <= s.pl_mark);
    assign rx_high = (s.rx.cnt >= s.rx_mark);

    // bus decode: a write is performed once address and data are both held
    assign wr_fire = s.aw_got && s.w_got && (s.wr_st == CEQ_BUS_IDLE);
    assign rd_fire = ARVALID && ARREADY;

    // pushes beyond capacity are dropped silently; software watches the level
    assign tx_push = wr_fire && (s.aw_addr == OFS_TX_QUEUE_PUSH) && !tx_full;
    assign pl_push = wr_fire && (s.aw_addr == OFS_RX_FREE_POOL_PUSH) && !pl_full;
    assign tx_pop = TXQ_VALID && TXQ_READY;
    assign pl_pop = POOL_VALID && POOL_TAKE;
    // low address bits are ignored here as in the read decode, so a pop never returns data without removing it
    assign rx_pop = rd_fire && ({ARADDR[7:2], 2'b00} == OFS_RX_QUEUE_POP) && (s.rx.cnt != '0);

    // a low pool lets only oam through; a discarded packet is always taken
    assign rx_discard = RXQ_VALID && pl_low && !RXQ_OAM;
    assign RXQ_READY = rx_discard || (!rx_full && !(pl_low && !RXQ_OAM));
    assign rx_push = RXQ_VALID && RXQ_READY && !rx_discard;

    assign irq_event[IRQ_TX_LOW] = tx_low;
    assign irq_event[IRQ_POOL_LOW] = pl_low;
    assign irq_event[IRQ_RX_HIGH] = rx_high;
    assign irq_event[IRQ_RX_DROP] = rx_discard;

    // handshake outputs
    assign AWREADY = !s.aw_got;
    assign WREADY = !s.w_got;
    assign ARREADY = (s.rd_st == CEQ_BUS_IDLE);
    assign BVALID = (s.wr_st == CEQ_BUS_RESP);
    assign BRESP = s.bresp;
    assign RVALID = (s.rd_st == CEQ_BUS_RESP);
    assign RDATA = s.rdata;
    assign RRESP = s.rresp;
    assign TXQ_VALID = (s.tx.cnt != '0);
    assign POOL_VALID = (s.pl.cnt != '0);
    assign TXQ_ADDR = {tx_mem[tx_rp], ID_LSB'(0)};
    assign POOL_ADDR = {pl_mem[s.pl.rp], ID_LSB'(0)};
    assign RXQ_DROP = s.drop;
    assign IRQ = |(s.irq_status & s.irq_mask);

    function automatic logic [31:0] read_word(input logic [7:0] a, input ceq_state_s st,
                                              input logic [ID_W-1:0] head);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            OFS_TX_QUEUE_COUNT: v = 32'(st.tx.cnt[TX_CW-1:0]);
            OFS_TX_QUEUE_LOW_MARK: v = 32'(st.tx_mark);
            OFS_RX_FREE_POOL_COUNT: v = 32'(st.pl.cnt);
            OFS_RX_FREE_POOL_LOW_MARK: v = 32'(st.pl_mark);
            OFS_RX_QUEUE_POP: v = (st.rx.cnt != '0) ? 32'(head) : 32'h0;
            OFS_RX_QUEUE_COUNT: v = 32'(st.rx.cnt);
            OFS_RX_QUEUE_HIGH_MARK: v = 32'(st.rx_mark);
            OFS_IRQ_STATUS: v = 32'(st.irq_status);
            OFS_IRQ_MASK: v = 32'(st.irq_mask);
            default: v = 32'h0;
        endcase
        return v;
    endfunction : read_word

    function automatic logic known_addr(input logic [7:0] a);
        logic k;
        k = 1'b0;
        case (a)
            OFS_TX_QUEUE_PUSH, OFS_TX_QUEUE_COUNT, OFS_TX_QUEUE_LOW_MARK,
            OFS_RX_FREE_POOL_PUSH, OFS_RX_FREE_POOL_COUNT, OFS_RX_FREE_POOL_LOW_MARK,
            OFS_RX_QUEUE_POP, OFS_RX_QUEUE_COUNT, OFS_RX_QUEUE_HIGH_MARK,
            OFS_IRQ_STATUS, OFS_IRQ_MASK: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction : known_addr

    always_comb begin
        next_s = s;
        // write address and data are taken in either order
        if (AWVALID && AWREADY) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = {AWADDR[7:2], 2'b00};
        end
        if (WVALID && WREADY) begin
            next_s.w_got = 1'b1;
            next_s.w_data = WDATA;
            next_s.w_strb = WSTRB;
        end
        case (s.wr_st)
            CEQ_BUS_IDLE: begin
                if (wr_fire) begin
                    next_s.wr_st = CEQ_BUS_RESP;
                    next_s.bresp = known_addr(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            CEQ_BUS_RESP: begin
                if (BREADY) begin
                    next_s.wr_st = CEQ_BUS_IDLE;
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                end
            end
            default: next_s.wr_st = CEQ_BUS_IDLE;
        endcase
        // marks steer the comparators; only the low byte lane carries them
        if (wr_fire && s.w_strb[0]) begin
            case (s.aw_addr)
                OFS_TX_QUEUE_LOW_MARK: next_s.tx_mark = s.w_data[TX_CW-1:0];
                OFS_RX_FREE_POOL_LOW_MARK: next_s.pl_mark = s.w_data[RX_CW-1:0];
                OFS_RX_QUEUE_HIGH_MARK: next_s.rx_mark = s.w_data[RX_CW-1:0];
                OFS_IRQ_MASK: next_s.irq_mask = s.w_data[IRQ_W-1:0];
                default: next_s.tx_mark = s.tx_mark;
            endcase
        end
        // write one to clear, a standing event sets again in the same cycle
        next_s.irq_status = s.irq_status;
        if (wr_fire && (s.aw_addr == OFS_IRQ_STATUS) && s.w_strb[0]) begin
            next_s.irq_status = s.irq_status & ~s.w_data[IRQ_W-1:0];
        end
        next_s.irq_status = next_s.irq_status | irq_event;
        // read channel: a read of the pop register commits the removal when taken
        case (s.rd_st)
            CEQ_BUS_IDLE: begin
                if (rd_fire) begin
                    next_s.rd_st = CEQ_BUS_RESP;
                    next_s.rdata = read_word({ARADDR[7:2], 2'b00}, s, rx_mem[s.rx.rp]);
                    next_s.rresp = known_addr({ARADDR[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            CEQ_BUS_RESP: begin
                if (RREADY) begin
                    next_s.rd_st = CEQ_BUS_IDLE;
                end
            end
            default: next_s.rd_st = CEQ_BUS_IDLE;
        endcase
        // ring pointers and levels
        next_s.tx.wp = RX_PW'(tx_wp + TX_PW'(tx_push));
        next_s.tx.rp = RX_PW'(tx_rp + TX_PW'(tx_pop));
        next_s.tx.cnt = s.tx.cnt + RX_CW'(tx_push) - RX_CW'(tx_pop);
        next_s.pl.wp = s.pl.wp + RX_PW'(pl_push);
        next_s.pl.rp = s.pl.rp + RX_PW'(pl_pop);
        next_s.pl.cnt = s.pl.cnt + RX_CW'(pl_push) - RX_CW'(pl_pop);
        next_s.rx.wp = s.rx.wp + RX_PW'(rx_push);
        next_s.rx.rp = s.rx.rp + RX_PW'(rx_pop);
        next_s.rx.cnt = s.rx.cnt + RX_CW'(rx_push) - RX_CW'(rx_pop);
        next_s.drop = rx_discard;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.wr_st <= CEQ_BUS_IDLE;
            s.rd_st <= CEQ_BUS_IDLE;
            s.bresp <= RESP_OKAY;
            s.rresp <= RESP_OKAY;
            s.tx.cnt <= RX_CW'(RST_TX_COUNT);
            s.tx_mark <= RST_TX_MARK;
            s.pl.cnt <= RST_RX_COUNT;
            s.pl_mark <= RST_RX_MARK;
            s.rx.cnt <= RST_RX_COUNT;
            s.rx_mark <= RST_RX_MARK;
            s.irq_status <= RST_IRQ;
            s.irq_mask <= RST_IRQ;
        end else begin
            s <= next_s;
        end
    end

    // storage needs no reset: contents are only read below the level
    always_ff @(posedge CLK) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= wr_id;
        end
        if (pl_push) begin
            pl_mem[s.pl.wp] <= wr_id;
        end
        if (rx_push) begin
            rx_mem[s.rx.wp] <= RXQ_ADDR[ADDR_W-1:ID_LSB];
        end
    end
endmodule : ceq_buffer_queues

/* shared/ceq_pkg.sv */
// buffer-id queue manager: register map, field layout, widths and state types
// assumes one packet-processing clock shared by the bus and the ethernet engine
package ceq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_TX_QUEUE_PUSH = 8'h18;
    localparam logic [7:0] OFS_TX_QUEUE_COUNT = 8'h1c;
    localparam logic [7:0] OFS_TX_QUEUE_LOW_MARK = 8'h20;
    localparam logic [7:0] OFS_RX_FREE_POOL_PUSH = 8'h24;
    localparam logic [7:0] OFS_RX_FREE_POOL_COUNT = 8'h28;
    localparam logic [7:0] OFS_RX_FREE_POOL_LOW_MARK = 8'h2c;
    localparam logic [7:0] OFS_RX_QUEUE_POP = 8'h30;
    localparam logic [7:0] OFS_RX_QUEUE_COUNT = 8'h34;
    localparam logic [7:0] OFS_RX_QUEUE_HIGH_MARK = 8'h38;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
    // buffer id and sdram address layout
    localparam int ID_W = 13;
    localparam int ADDR_W = 24;
    localparam int ID_LSB = 11;
    // structure sizes
    localparam int TX_DEPTH = 32;
    localparam int RX_DEPTH = 128;
    localparam int TX_PW = 5;
    localparam int TX_CW = 6;
    localparam int RX_PW = 7;
    localparam int RX_CW = 8;
    // interrupt status bit positions
    localparam int IRQ_TX_LOW = 0;
    localparam int IRQ_POOL_LOW = 1;
    localparam int IRQ_RX_HIGH = 2;
    localparam int IRQ_RX_DROP = 3;
    localparam int IRQ_W = 4;
    // reset values
    localparam logic [TX_CW-1:0] RST_TX_COUNT = 6'h00;
    localparam logic [TX_CW-1:0] RST_TX_MARK = 6'h00;
    localparam logic [RX_CW-1:0] RST_RX_COUNT = 8'h00;
    localparam logic [RX_CW-1:0] RST_RX_MARK = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CEQ_BUS_IDLE = 2'b00,
        CEQ_BUS_RESP = 2'b01
    } ceq_bus_e;

    // one ring: write pointer, read pointer, level
    typedef struct packed {
        logic [RX_PW-1:0] wp;
        logic [RX_PW-1:0] rp;
        logic [RX_CW-1:0] cnt;
    } ceq_ring_s;

    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        ceq_bus_e wr_st;
        logic [1:0] bresp;
        ceq_bus_e rd_st;
        logic [31:0] rdata;
        logic [1:0] rresp;
        ceq_ring_s tx;
        ceq_ring_s pl;
        ceq_ring_s rx;
        logic [TX_CW-1:0] tx_mark;
        logic [RX_CW-1:0] pl_mark;
        logic [RX_CW-1:0] rx_mark;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic drop;
    } ceq_state_s;
endpackage : ceq_pkg

/* test/ceq_buffer_queues_monitor.sv */
// port-level checker for the buffer-id queue manager
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
module ceq_buffer_queues_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // bus handshakes
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic [31:0] RDATA,
    // engine side
    input wire logic TXQ_VALID,
    input wire logic [23:0] TXQ_ADDR,
    input wire logic TXQ_READY,
    input wire logic POOL_VALID,
    input wire logic [23:0] POOL_ADDR,
    input wire logic RXQ_VALID,
    input wire logic RXQ_OAM,
    input wire logic RXQ_READY,
    input wire logic RXQ_DROP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer late");
    chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    chk_pop_upper: assert property (RVALID |-> RDATA[31:13] == 19'h0)
        else $error("read data upper bits set");
    chk_tx_align: assert property (TXQ_VALID |-> TXQ_ADDR[10:0] == 11'h0)
        else $error("transmit address not aligned");
    chk_pool_align: assert property (POOL_VALID |-> POOL_ADDR[10:0] == 11'h0)
        else $error("pool address not aligned");
    chk_tx_head_hold: assert property (TXQ_VALID && !TXQ_READY |=> TXQ_VALID && $stable(TXQ_ADDR))
        else $error("transmit head moved");
    chk_oam_kept: assert property (RXQ_VALID && RXQ_READY && RXQ_OAM |=> !RXQ_DROP)
        else $error("oam packet dropped");
    chk_drop_cause: assert property ($rose(RXQ_DROP) |-> $past(RXQ_VALID && RXQ_READY && !RXQ_OAM))
        else $error("drop without non-oam packet");

    cover property (RXQ_DROP);
    cover property (TXQ_VALID && TXQ_READY);
    cover property (RVALID && RDATA != 32'h0);
endmodule : ceq_buffer_queues_monitor

bind ceq_buffer_queues ceq_buffer_queues_monitor u_mon (.*);

/* test/ceq_buffer_queues_tb.sv */
// self-checking bench for the buffer-id queue manager
// assumes the engine model in test/ and a 100 MHz clock
`timescale 1ns/1ns
module ceq_buffer_queues_tb;
    localparam int MARK = 2;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b1, ARVALID = 1'b0, RREADY = 1'b1;
    logic [31:0] WDATA = 32'h0, RDATA, d;
    logic [3:0] WSTRB = 4'hf;
    logic [1:0] BRESP, RRESP, r, last_bresp;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXQ_VALID, POOL_VALID, RXQ_READY, RXQ_DROP, IRQ;
    logic TXQ_READY, POOL_TAKE, RXQ_VALID, RXQ_OAM;
    logic [23:0] TXQ_ADDR, POOL_ADDR, RXQ_ADDR;
    logic tx_go = 1'b0, rx_req = 1'b0, rx_oam = 1'b0;
    logic [31:0] seed = 32'h2d44;
    logic [7:0] rst_regs[6] = '{8'h1c, 8'h20, 8'h28, 8'h2c, 8'h34, 8'h38};
    logic [12:0] ids[$];
    int miscompares = 0, total_checks = 0, cycles = 0, n;

    ceq_buffer_queues u_dut (.*);
    ceq_engine_model u_eng (.clk(CLK), .rst(RST), .tx_go(tx_go), .rx_req(rx_req), .rx_oam(rx_oam),
        .txq_valid(TXQ_VALID), .txq_addr(TXQ_ADDR), .txq_ready(TXQ_READY), .pool_valid(POOL_VALID),
        .pool_addr(POOL_ADDR), .pool_take(POOL_TAKE), .rxq_valid(RXQ_VALID), .rxq_addr(RXQ_ADDR),
        .rxq_oam(RXQ_OAM), .rxq_ready(RXQ_READY));

    always #5 CLK = ~CLK;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [31:0] exp_stat(input int tx, input int pl, input int rx, input logic dr);
        return {28'h0, dr, rx >= MARK, pl <= MARK, tx <= MARK};
    endfunction : exp_stat

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // both write channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        logic ao;
        logic wo;
        ao = 1'b0;
        wo = 1'b0;
        AWADDR <= a;
        WDATA <= dv;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!(ao && wo)) begin
            @(posedge CLK);
            ao = ao | AWREADY;
            wo = wo | WREADY;
            AWVALID <= !ao;
            WVALID <= !wo;
        end
        do @(posedge CLK); while (BVALID !== 1'b1);
        last_bresp = BRESP;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rr);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        dv = RDATA;
        rr = RRESP;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] dv;
        logic [1:0] rr;
        rd(a, dv, rr);
        chk(dv, e);
    endtask : rchk
    // one free buffer taken by the engine and offered back as a packet
    task automatic pkt(input logic oam, input logic dr);
        rx_req <= 1'b1;
        rx_oam <= oam;
        @(posedge CLK);
        rx_req <= 1'b0;
        do @(posedge CLK); while (u_eng.pool_take || u_eng.rxq_valid);
        chk({31'h0, RXQ_DROP}, {31'h0, dr});
    endtask : pkt

    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        foreach (rst_regs[i]) rchk(rst_regs[i], 32'h0);
        rd(8'h3c, d, r);
        chk({30'h0, r}, 32'h2);
        $display("test reset values done");
        wr(8'h20, MARK);
        wr(8'h2c, MARK);
        wr(8'h38, MARK);
        chk({30'h0, last_bresp}, 32'h0);
        // a mark write without the low byte lane must leave the mark alone
        WSTRB <= 4'he;
        wr(8'h20, 32'h5);
        WSTRB <= 4'hf;
        rchk(8'h20, MARK);
        wr(8'h3c, 32'h1);
        chk({30'h0, last_bresp}, 32'h2);
        wr(8'h40, 32'hf);
        wr(8'h44, 32'hf);
        rchk(8'h40, exp_stat(0, 0, 0, 1'b0));
        chk({31'h0, IRQ}, 32'h1);
        seed = xs(seed);
        n = seed[2:0] + 1;
        repeat (n) begin
            seed = xs(seed);
            ids.push_back(seed[12:0]);
            wr(8'h18, seed);
        end
        rchk(8'h1c, n);
        wr(8'h40, 32'hf);
        rchk(8'h40, exp_stat(n, 0, 0, 1'b0));
        tx_go <= 1'b1;
        do @(posedge CLK); while (u_eng.tx_seen.size() < n);
        tx_go <= 1'b0;
        foreach (ids[i]) chk(u_eng.tx_seen[i], {ids[i], 11'h0});
        rchk(8'h1c, 32'h0);
        rchk(8'h40, exp_stat(0, 0, 0, 1'b0));
        $display("test transmit queue done");
        ids.delete();
        repeat (4) begin
            seed = xs(seed);
            ids.push_back(seed[12:0]);
            wr(8'h24, seed);
        end
        rchk(8'h28, 32'h4);
        wr(8'h40, 32'hf);
        pkt(1'b0, 1'b0);
        pkt(1'b0, 1'b1);
        pkt(1'b1, 1'b0);
        rchk(8'h28, 32'h1);
        rchk(8'h34, 32'h2);
        rchk(8'h40, exp_stat(0, 1, 2, 1'b1));
        wr(8'h44, 32'h4);
        chk({31'h0, IRQ}, 32'h1);
        rchk(8'h30, ids[0]);
        rchk(8'h30, ids[2]);
        rchk(8'h30, 32'h0);
        rchk(8'h34, 32'h0);
        wr(8'h40, 32'hf);
        chk({31'h0, IRQ}, 32'h0);
        $display("test receive path done");
        end_of_test();
    end
endmodule : ceq_buffer_queues_tb

/* test/ceq_engine_model.sv */
// ethernet engine stand-in: drains the transmit queue, takes free buffers, offers packets
// assumes the bench pulses rx_req only while the free pool holds a buffer
`timescale 1ns/1ns
module ceq_engine_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench commands
    input wire logic tx_go,
    input wire logic rx_req,
    input wire logic rx_oam,
    // transmit queue
    input wire logic txq_valid,
    input wire logic [23:0] txq_addr,
    output logic txq_ready,
    // free pool
    input wire logic pool_valid,
    input wire logic [23:0] pool_addr,
    output logic pool_take,
    // receive queue
    output logic rxq_valid,
    output logic [23:0] rxq_addr,
    output logic rxq_oam,
    input wire logic rxq_ready
);
    logic [7:0] lfsr = 8'h5b;
    logic [23:0] tx_seen[$];
    initial begin
        txq_ready = 1'b0;
        pool_take = 1'b0;
        rxq_valid = 1'b0;
        rxq_addr = 24'h0;
        rxq_oam = 1'b0;
    end
    always @(posedge clk) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        // stalls about half the time so the head has to wait
        txq_ready <= tx_go && lfsr[0] && !rst;
        pool_take <= rx_req && pool_valid && !rst;
        if (txq_valid && txq_ready) begin
            tx_seen.push_back(txq_addr);
        end
        if (pool_take) begin
            rxq_valid <= 1'b1;
            rxq_addr <= pool_addr;
            rxq_oam <= rx_oam;
        end else if (rxq_valid && rxq_ready) begin
            // released lines must not keep the last value
            rxq_valid <= 1'b0;
            rxq_addr <= ~rxq_addr;
            rxq_oam <= ~rxq_oam;
        end
    end
endmodule : ceq_engine_model
